// [rtl/lbm_bucket.sv]
/*
 * One leaky-bucket accumulator with its own leak span and alarm limits.
 * Assumes tick pulses once per monitoring cycle and fail is a level or
 * pulse that marks bad behaviour of the monitored input.
 */
`timescale 1ns/10ps
module lbm_bucket import lbm_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tick,
    input wire logic fail,
    input wire logic [LBM_LEAK_W-1:0] leak_code,
    input wire logic [7:0] raise_lvl,
    input wire logic [7:0] clear_lvl,
    input wire logic [7:0] size_lvl,
    output logic [7:0] level,
    output logic alarm,
    output logic raise_evt,
    output logic clear_evt
);
    logic fail_seen_r;
    logic [2:0] clean_r;
    logic [2:0] span_last;
    logic bad_cycle;

    assign bad_cycle = fail_seen_r | fail;
    // Span of clean cycles per decrement: 1, 2, 4 or 8
    assign span_last = 3'((4'h1 << leak_code) - 4'h1);

    // ------------------------------------------------------------------
    // Failure seen during the running cycle
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fail_seen_r <= 1'b0;
        end else if (tick) begin
            fail_seen_r <= 1'b0;
        end else if (fail) begin
            fail_seen_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level <= 8'h0;
            clean_r <= 3'h0;
        end else if (tick) begin
            if (bad_cycle) begin
                clean_r <= 3'h0;
                if (level < size_lvl) begin
                    level <= level + 8'h1;
                end
            end else if (clean_r >= span_last) begin
                clean_r <= 3'h0;
                if (level != 8'h0) begin
                    level <= level - 8'h1;
                end
            end else begin
                clean_r <= clean_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Alarm with events
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm <= 1'b0;
            raise_evt <= 1'b0;
            clear_evt <= 1'b0;
        end else begin
            raise_evt <= 1'b0;
            clear_evt <= 1'b0;
            if (!alarm && level >= raise_lvl) begin
                alarm <= 1'b1;
                raise_evt <= 1'b1;
            end else if (alarm && level <= clear_lvl) begin
                alarm <= 1'b0;
                clear_evt <= 1'b1;
            end
        end
    end
endmodule

// [rtl/lbm_tick.sv]
/*
 * Monitoring-cycle timer: one-cycle pulse at the end of every cycle.
 * Assumes a free-running system clock.
 */
`timescale 1ns/10ps
module lbm_tick import lbm_pkg::*; #(
    parameter int CYCLE_CLKS = LBM_CYCLE_CLKS
) (
    input wire logic aclk,
    input wire logic aresetn,
    output logic tick
);
    localparam logic [31:0] LAST = 32'(CYCLE_CLKS - 1);

    logic [31:0] cnt_r;

    // ------------------------------------------------------------------
    // Cycle counter
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_r == LAST) begin
            cnt_r <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule

// [rtl/lbm_top.sv]
/*
 * Leaky-bucket activity monitor for two inputs, each judged by its own
 * bucket configuration, with an AXI4-Lite register slave and interrupt.
 * Assumes fail inputs synchronous to aclk and a single AXI master with
 * at most one write and one read in flight.
 */
`timescale 1ns/10ps
module lbm_top import lbm_pkg::*; #(
    parameter int CYCLE_CLKS = LBM_CYCLE_CLKS,
    parameter int ADDR_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] fail_in,
    output logic [1:0] alarm_out,
    output logic irq,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic aw_held_r;
    logic w_held_r;
    logic wr_go;
    logic [7:0] wr_idx;
    logic wr_hit;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;
    logic rd_hit;

    logic [7:0] raise_lvl_r [2];
    logic [7:0] clear_lvl_r [2];
    logic [7:0] size_r [2];
    logic [LBM_LEAK_W-1:0] leak_r [2];
    logic [3:0] irq_status_r;
    logic [3:0] irq_mask_r;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    logic tick;
    logic [7:0] level [2];
    logic [1:0] alarm;
    logic [1:0] raise_evt;
    logic [1:0] clear_evt;

    assign wr_idx = 8'(awaddr_r >> 2);
    assign rd_idx = 8'(s_axi_araddr >> 2);
    assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;

    // ------------------------------------------------------------------
    // Cycle timer and the two buckets
    // ------------------------------------------------------------------
    lbm_tick #(
        .CYCLE_CLKS(CYCLE_CLKS)
    ) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick)
    );

    for (genvar i = 0; i < 2; i++) begin : g_bucket
        // Each bucket reads only its own configuration registers
        lbm_bucket u_bucket (
            .aclk(aclk),
            .aresetn(aresetn),
            .tick(tick),
            .fail(fail_in[i]),
            .leak_code(leak_r[i]),
            .raise_lvl(raise_lvl_r[i]),
            .clear_lvl(clear_lvl_r[i]),
            .size_lvl(size_r[i]),
            .level(level[i]),
            .alarm(alarm[i]),
            .raise_evt(raise_evt[i]),
            .clear_evt(clear_evt[i])
        );
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_out <= 2'h0;
        end else begin
            alarm_out <= alarm;
        end
    end

    // ------------------------------------------------------------------
    // Write address and data capture
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            s_axi_awready <= ~aw_held_r & ~s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 8'h0;
            wstrb0_r <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata[7:0];
            wstrb0_r <= s_axi_wstrb[0];
            s_axi_wready <= 1'b0;
        end else begin
            if (wr_go) begin
                w_held_r <= 1'b0;
            end
            s_axi_wready <= ~w_held_r & ~s_axi_bvalid;
        end
    end

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    always_comb begin
        unique case (wr_idx)
            LBM_IDX_RAISE_LVL_CFG0, LBM_IDX_CLEAR_LVL_CFG0,
            LBM_IDX_SIZE_CFG0, LBM_IDX_LEAK_RATE_CFG0,
            LBM_IDX_RAISE_LVL_CFG1, LBM_IDX_CLEAR_LVL_CFG1,
            LBM_IDX_SIZE_CFG1, LBM_IDX_LEAK_RATE_CFG1,
            LBM_IDX_IRQ_STATUS, LBM_IDX_IRQ_MASK: begin
                wr_hit = 1'b1;
            end
            LBM_IDX_LEVEL_CFG0, LBM_IDX_LEVEL_CFG1,
            LBM_IDX_ALARM_STATE: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LBM_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? LBM_RESP_OKAY : LBM_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 2; i++) begin
                raise_lvl_r[i] <= LBM_RST_RAISE_LVL;
                clear_lvl_r[i] <= LBM_RST_CLEAR_LVL;
                size_r[i] <= LBM_RST_SIZE;
                leak_r[i] <= LBM_RST_LEAK_RATE[LBM_LEAK_W-1:0];
            end
            irq_mask_r <= LBM_RST_IRQ_MASK;
        end else if (wr_go && wstrb0_r) begin
            unique case (wr_idx)
                LBM_IDX_RAISE_LVL_CFG0: raise_lvl_r[0] <= wdata_r;
                LBM_IDX_CLEAR_LVL_CFG0: clear_lvl_r[0] <= wdata_r;
                LBM_IDX_SIZE_CFG0: size_r[0] <= wdata_r;
                LBM_IDX_LEAK_RATE_CFG0: begin
                    leak_r[0] <= wdata_r[LBM_LEAK_LSB +: LBM_LEAK_W];
                end
                LBM_IDX_RAISE_LVL_CFG1: raise_lvl_r[1] <= wdata_r;
                LBM_IDX_CLEAR_LVL_CFG1: clear_lvl_r[1] <= wdata_r;
                LBM_IDX_SIZE_CFG1: size_r[1] <= wdata_r;
                LBM_IDX_LEAK_RATE_CFG1: begin
                    leak_r[1] <= wdata_r[LBM_LEAK_LSB +: LBM_LEAK_W];
                end
                LBM_IDX_IRQ_MASK: irq_mask_r <= wdata_r[3:0];
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, write one to clear, a new event wins
    // ------------------------------------------------------------------
    assign irq_set = {clear_evt, raise_evt};
    assign irq_clr = (wr_go && wstrb0_r && wr_idx == LBM_IDX_IRQ_STATUS)
        ? wdata_r[3:0] : 4'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_r <= 4'h0;
        end else begin
            irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------------
    always_comb begin
        rd_data = 8'h0;
        rd_hit = 1'b1;
        unique case (rd_idx)
            LBM_IDX_RAISE_LVL_CFG0: rd_data = raise_lvl_r[0];
            LBM_IDX_CLEAR_LVL_CFG0: rd_data = clear_lvl_r[0];
            LBM_IDX_SIZE_CFG0: rd_data = size_r[0];
            LBM_IDX_LEAK_RATE_CFG0: rd_data = 8'(leak_r[0]);
            LBM_IDX_RAISE_LVL_CFG1: rd_data = raise_lvl_r[1];
            LBM_IDX_CLEAR_LVL_CFG1: rd_data = clear_lvl_r[1];
            LBM_IDX_SIZE_CFG1: rd_data = size_r[1];
            LBM_IDX_LEAK_RATE_CFG1: rd_data = 8'(leak_r[1]);
            LBM_IDX_IRQ_STATUS: rd_data = 8'(irq_status_r);
            LBM_IDX_IRQ_MASK: rd_data = 8'(irq_mask_r);
            LBM_IDX_LEVEL_CFG0: rd_data = level[0];
            LBM_IDX_LEVEL_CFG1: rd_data = level[1];
            LBM_IDX_ALARM_STATE: rd_data = 8'(alarm);
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= LBM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= 32'(rd_data);
            s_axi_rresp <= rd_hit ? LBM_RESP_OKAY : LBM_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule

// [shared/lbm_pkg.sv]
/*
 * Constants of the leaky-bucket activity monitor: register indices,
 * field positions, reset values, timing counts and bus encodings.
 * Assumes the design runs from one 25 MHz system clock.
 */
// How it works
// - Each 128 ms cycle with a failed or erratic input adds one.
// - One is taken off per 1, 2, 4 or 8 clean cycles in a row.
// - Drain speed is the fill speed, or its half, quarter or eighth.
// - Alarm is raised once the bucket reaches its eight-bit upper limit.
// - Configuration 1 drains by its own leak setting, not configuration 0.
// - Alarm is cleared once the bucket falls to its eight-bit lower limit.
// - The bucket never counts beyond its eight-bit maximum size.
package lbm_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int LBM_CLK_HZ = 25_000_000;
    localparam int LBM_CYCLE_MS = 128;
    localparam int LBM_CYCLE_CLKS = LBM_CYCLE_MS * (LBM_CLK_HZ / 1000);

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] LBM_IDX_RAISE_LVL_CFG0 = 8'h50;
    localparam logic [7:0] LBM_IDX_CLEAR_LVL_CFG0 = 8'h51;
    localparam logic [7:0] LBM_IDX_SIZE_CFG0 = 8'h52;
    localparam logic [7:0] LBM_IDX_LEAK_RATE_CFG0 = 8'h53;
    localparam logic [7:0] LBM_IDX_RAISE_LVL_CFG1 = 8'h54;
    localparam logic [7:0] LBM_IDX_CLEAR_LVL_CFG1 = 8'h55;
    localparam logic [7:0] LBM_IDX_SIZE_CFG1 = 8'h56;
    localparam logic [7:0] LBM_IDX_LEAK_RATE_CFG1 = 8'h57;
    localparam logic [7:0] LBM_IDX_IRQ_STATUS = 8'h60;
    localparam logic [7:0] LBM_IDX_IRQ_MASK = 8'h61;
    localparam logic [7:0] LBM_IDX_LEVEL_CFG0 = 8'h62;
    localparam logic [7:0] LBM_IDX_LEVEL_CFG1 = 8'h63;
    localparam logic [7:0] LBM_IDX_ALARM_STATE = 8'h64;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int LBM_LEAK_LSB = 0;
    localparam int LBM_LEAK_W = 2;
    localparam logic [7:0] LBM_RST_LEAK_RATE = 8'h01;
    localparam logic [7:0] LBM_RST_RAISE_LVL = 8'h06;
    localparam logic [7:0] LBM_RST_CLEAR_LVL = 8'h04;
    localparam logic [7:0] LBM_RST_SIZE = 8'h08;
    localparam logic [3:0] LBM_RST_IRQ_MASK = 4'h0;
    // Status bits: [1:0] alarm raised per config, [3:2] alarm cleared
    localparam int LBM_IRQ_RAISE_LSB = 0;
    localparam int LBM_IRQ_CLEAR_LSB = 2;

    // ------------------------------------------------------------------
    // AXI4-Lite
    // ------------------------------------------------------------------
    localparam logic [1:0] LBM_RESP_OKAY = 2'h0;
    localparam logic [1:0] LBM_RESP_SLVERR = 2'h2;

endpackage

// [verification/lbm_top_bench.sv]
/*
 * Self-checking bench for lbm_top: registers, fill, limits, leak spans
 * and interrupt. Assumes a shortened monitoring cycle of 16 clocks.
 */
`timescale 1ns/10ps
module lbm_top_bench;
import lbm_pkg::*;
    // ------------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------------
    localparam int C = 16;
    logic aclk = 0;
    logic aresetn = 0;
    logic [1:0] fail_in = 0;
    logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
    logic [9:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [3:0] ws = 4'hf;
    logic [1:0] alarm_out, brsp, rrsp;
    logic irq, awr, wrdy, bv, arr, rv;
    int err_total = 0, n_checks = 0, cyc = 0;
    lbm_top #(.CYCLE_CLKS(C)) lbm_top_i (
        .aclk(aclk), .aresetn(aresetn), .fail_in(fail_in),
        .alarm_out(alarm_out), .irq(irq), .s_axi_awaddr(awa),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(brsp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rrsp), .s_axi_rvalid(rv), .s_axi_rready(rr));
    initial forever #20 aclk = ~aclk;
    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awa <= {a, 2'b00};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        chk("bresp", 8'h00, {6'h0, brsp});
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        ara <= {a, 2'b00};
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rr <= 1'b0;
        d = rdat[7:0];
        r = rrsp;
    endtask
    // Polls a level register until it shows t; tm is the cycle seen
    task automatic wl(input logic [7:0] a, input logic [7:0] t,
                      output int tm);
        logic [7:0] v;
        logic [1:0] r;
        int n;
        v = ~t;
        n = 0;
        while (v !== t && n < 600) begin
            rd(a, v, r);
            n++;
        end
        tm = cyc;
        chk("level", t, v);
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        logic [7:0] v;
        logic [1:0] r;
        rd(LBM_IDX_LEAK_RATE_CFG0, v, r);
        chk("leak0", 8'h01, v);
        rd(LBM_IDX_RAISE_LVL_CFG1, v, r);
        chk("raise1", 8'h06, v);
        rd(LBM_IDX_CLEAR_LVL_CFG0, v, r);
        chk("clear0", 8'h04, v);
        rd(LBM_IDX_SIZE_CFG1, v, r);
        chk("size1", 8'h08, v);
        wr(LBM_IDX_LEAK_RATE_CFG0, 8'hff);
        rd(LBM_IDX_LEAK_RATE_CFG0, v, r);
        chk("leak0 bits", 8'h03, v);
        ws <= 4'h0;
        wr(LBM_IDX_RAISE_LVL_CFG1, 8'h11);
        ws <= 4'hf;
        rd(LBM_IDX_RAISE_LVL_CFG1, v, r);
        chk("strobe off", 8'h06, v);
        rd(8'h70, v, r);
        chk("unmapped", {6'h0, LBM_RESP_SLVERR}, {6'h0, r});
        $display("test regs done");
    endtask
    task automatic t_fill;
        logic [7:0] v;
        logic [1:0] r;
        wr(LBM_IDX_RAISE_LVL_CFG1, 8'h03);
        wr(LBM_IDX_CLEAR_LVL_CFG1, 8'h01);
        wr(LBM_IDX_LEAK_RATE_CFG1, 8'h03);
        for (int i = 1; i <= 3; i++) begin
            fail_in <= 2'b10;
            @(posedge aclk);
            fail_in <= 2'b00;
            repeat (C + 2) @(posedge aclk);
            rd(LBM_IDX_LEVEL_CFG1, v, r);
            chk("level1", 8'(i), v);
            chk("alarm1", {7'h0, i == 3}, {7'h0, alarm_out[1]});
        end
        fail_in <= 2'b10;
        repeat (10 * C) @(posedge aclk);
        fail_in <= 2'b00;
        rd(LBM_IDX_LEVEL_CFG1, v, r);
        chk("level1 max", 8'h08, v);
        rd(LBM_IDX_LEVEL_CFG0, v, r);
        chk("level0", 8'h00, v);
        rd(LBM_IDX_IRQ_STATUS, v, r);
        chk("status", 8'h02, v);
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(LBM_IDX_IRQ_MASK, 8'h02);
        repeat (2) @(posedge aclk);
        chk("irq", 8'h01, {7'h0, irq});
        wr(LBM_IDX_IRQ_STATUS, 8'h02);
        repeat (2) @(posedge aclk);
        chk("irq clr", 8'h00, {7'h0, irq});
        $display("test fill done");
    endtask
    task automatic t_leak(input int k);
        logic [7:0] v;
        logic [1:0] r;
        logic ok;
        int t1, t2;
        wr(LBM_IDX_LEAK_RATE_CFG0, 8'(k));
        wr(LBM_IDX_LEAK_RATE_CFG1, 8'(3 - k));
        fail_in <= 2'b01;
        repeat (10 * C) @(posedge aclk);
        fail_in <= 2'b00;
        wr(LBM_IDX_IRQ_STATUS, 8'h0f);
        wl(LBM_IDX_LEVEL_CFG0, 8'h07, t1);
        wl(LBM_IDX_LEVEL_CFG0, 8'h06, t2);
        ok = (t2 - t1 <= (C << k) + 8) && (t2 - t1 >= (C << k) - 8);
        chk("span", 8'h01, {7'h0, ok});
        wl(LBM_IDX_LEVEL_CFG0, 8'h05, t1);
        chk("alarm hold", 8'h01, {7'h0, alarm_out[0]});
        wl(LBM_IDX_LEVEL_CFG0, 8'h04, t1);
        repeat (3) @(posedge aclk);
        chk("alarm clr", 8'h00, {7'h0, alarm_out[0]});
        wl(LBM_IDX_LEVEL_CFG0, 8'h00, t1);
        repeat (3 * (C << k)) @(posedge aclk);
        rd(LBM_IDX_LEVEL_CFG0, v, r);
        chk("floor", 8'h00, v);
        rd(LBM_IDX_IRQ_STATUS, v, r);
        chk("clr evt", 8'h04, v & 8'h04);
        fail_in <= 2'b10;
        repeat (10 * C) @(posedge aclk);
        fail_in <= 2'b00;
        wl(LBM_IDX_LEVEL_CFG1, 8'h07, t1);
        wl(LBM_IDX_LEVEL_CFG1, 8'h06, t2);
        ok = (t2 - t1 <= (C << (3 - k)) + 8) &&
            (t2 - t1 >= (C << (3 - k)) - 8);
        chk("span1", 8'h01, {7'h0, ok});
        $display("test leak %0d done", k);
    endtask
    // ------------------------------------------------------------------
    // Run and hang guard
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs();
        t_fill();
        for (int k = 0; k < 4; k++) t_leak(k);
        final_report();
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            final_report();
        end
    end
endmodule

// [verification/lbm_top_sva.sv]
/*
 * Port-level checks for lbm_top, bound into every instance.
 * Assumes fail inputs are meaningless while reset is held.
 */
`timescale 1ns/10ps
module lbm_top_sva #(
    parameter int CYCLE_CLKS = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] fail_in,
    input wire logic [1:0] alarm_out,
    input wire logic irq,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // ------------------------------------------------------------------
    // Clocks since each input last failed, saturating
    // ------------------------------------------------------------------
    // Ceiling just above one cycle, so full-length cycles still count
    localparam int SAT = CYCLE_CLKS + 4;
    int sf0_r;
    int sf1_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sf0_r <= SAT;
            sf1_r <= SAT;
        end else begin
            sf0_r <= fail_in[0] ? 0 : sf0_r + int'(sf0_r < SAT);
            sf1_r <= fail_in[1] ? 0 : sf1_r + int'(sf1_r < SAT);
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_rise_fail0: assert property (
        $rose(alarm_out[0]) |-> sf0_r <= CYCLE_CLKS + 3)
        else $error("alarm 0 rose without recent failure");
    chk_rise_fail1: assert property (
        $rose(alarm_out[1]) |-> sf1_r <= CYCLE_CLKS + 3)
        else $error("alarm 1 rose without recent failure");
    chk_fall_clean0: assert property (
        $fell(alarm_out[0]) |-> sf0_r >= CYCLE_CLKS)
        else $error("alarm 0 fell without a clean cycle");
    chk_fall_hold0: assert property (
        $fell(alarm_out[0]) |=> !alarm_out[0] [*8])
        else $error("alarm 0 rose again too soon");
    chk_aw_refused: assert property (
        s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
        else $error("second write address accepted too soon");
    chk_b_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    chk_b_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_r_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    cov_rise0: cover property ($rose(alarm_out[0]));
    cov_fall1: cover property ($fell(alarm_out[1]));
    cov_irq: cover property ($rose(irq));
endmodule

bind lbm_top lbm_top_sva #(.CYCLE_CLKS(CYCLE_CLKS)) lbm_top_sva_i (
    .aclk(aclk), .aresetn(aresetn), .fail_in(fail_in),
    .alarm_out(alarm_out), .irq(irq), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
